// [hw/e1_auto_sa_alarm_response.sv]
// Behaviour
// - with the first line-loss enable set and LOS or LFA, send Sa5 as 1 and Sa6 as 0000, A untouched.
// - with the first LOS enable set and LOS, send A as 1, Sa5 as 1 and Sa6 as 1110.
// - with the second line-loss enable set and LOS or LFA, send A as 1, Sa5 as 0, Sa6 as 0000.
// - with the third line-loss enable set and LOS or LFA, send A as 0, Sa5 as 1, Sa6 as 1100.
// - with the fourth line-loss enable set and LOS or LFA, send A as 0, Sa5 as 1, Sa6 as 1110.
// - with the power-fail enable set and loss of power, send A as 0, Sa5 as 1 and Sa6 as 1000.
// - a high power-loss input means loss of power, a low one means none.
// - with the combined enable set and power loss plus LOS or LFA, send A 1, Sa5 1, Sa6 1000.
// - with the aux enable set and LOS, send the alternating 10101010 on both Sa5 and Sa6.
// - a response fires only from this channel's receive conditions or its power-loss input, and only while enabled.
// - all eight enables are software read/write and clear to zero at reset.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module e1_auto_sa_alarm_response (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_b,
  input  wire logic [sa_auto_pkg::APB_ADDR_W-1:0]    paddr,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [sa_auto_pkg::APB_DATA_W-1:0]    pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic [sa_auto_pkg::APB_DATA_W-1:0]         prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  input  wire logic                                  signal_loss,
  input  wire logic                                  align_loss,
  input  wire logic                                  power_loss,
  input  wire logic                                  nfas_strobe,
  input  wire sa_auto_pkg::oh_bits_t                 src_bits,
  output sa_auto_pkg::oh_bits_t                      tx_bits,
  output logic                                       auto_active
);

  logic [sa_auto_pkg::CTRL_W-1:0]     ctrl_r;
  logic [sa_auto_pkg::CTRL_W-1:0]     ctrl_nxt;
  logic [sa_auto_pkg::APB_DATA_W-1:0] prdata_r;
  logic [sa_auto_pkg::APB_DATA_W-1:0] prdata_nxt;
  sa_auto_pkg::oh_bits_t              tx_r;
  sa_auto_pkg::oh_bits_t              tx_nxt;
  sa_auto_pkg::resp_sel_t             sel_r;
  sa_auto_pkg::resp_sel_t             sel_c;
  sa_auto_pkg::resp_t                 resp_c;

  wire                                setup_ph;
  wire                                access_ph;
  wire                                hit_ctrl;
  wire                                hit_stat;
  wire                                wr_ctrl;
  wire                                line_loss;
  wire [sa_auto_pkg::CTRL_W-1:0]      trig;
  wire [sa_auto_pkg::CTRL_W-1:0]      stat_word;
  wire [1:0]                          code_idx;
  wire                                aux_bit;
  wire                                code_bit;
  wire                                restart;

  // highest triggered bit wins
  function automatic sa_auto_pkg::resp_sel_t pick(input logic [7:0] t);
    sa_auto_pkg::resp_sel_t s;
    s = sa_auto_pkg::RESP_NONE;
    if (t[sa_auto_pkg::EN_LOSLFA1_BIT]) s = sa_auto_pkg::RESP_LOSLFA1;
    else if (t[sa_auto_pkg::EN_LOS1_BIT]) s = sa_auto_pkg::RESP_LOS1;
    else if (t[sa_auto_pkg::EN_LOSLFA2_BIT]) s = sa_auto_pkg::RESP_LOSLFA2;
    else if (t[sa_auto_pkg::EN_LOSLFA3_BIT]) s = sa_auto_pkg::RESP_LOSLFA3;
    else if (t[sa_auto_pkg::EN_LOSLFA4_BIT]) s = sa_auto_pkg::RESP_LOSLFA4;
    else if (t[sa_auto_pkg::EN_PWR_BIT]) s = sa_auto_pkg::RESP_PWR;
    else if (t[sa_auto_pkg::EN_PWRLINE_BIT]) s = sa_auto_pkg::RESP_PWRLINE;
    else if (t[sa_auto_pkg::EN_AUX_BIT]) s = sa_auto_pkg::RESP_AUX;
    return s;
  endfunction

  // fields: use_src, a_keep, a_val, sa5_val, sa6_code, aux
  function automatic sa_auto_pkg::resp_t resp_of(input sa_auto_pkg::resp_sel_t s);
    sa_auto_pkg::resp_t r;
    r = '{1'b1, 1'b1, 1'b0, 1'b0, sa_auto_pkg::SA6_ZERO, 1'b0};
    case (s)
      sa_auto_pkg::RESP_LOSLFA1: r = '{1'b0, 1'b1, 1'b0, 1'b1, sa_auto_pkg::SA6_ZERO, 1'b0};
      sa_auto_pkg::RESP_LOS1:    r = '{1'b0, 1'b0, 1'b1, 1'b1, sa_auto_pkg::SA6_LOS, 1'b0};
      sa_auto_pkg::RESP_LOSLFA2: r = '{1'b0, 1'b0, 1'b1, 1'b0, sa_auto_pkg::SA6_ZERO, 1'b0};
      sa_auto_pkg::RESP_LOSLFA3: r = '{1'b0, 1'b0, 1'b0, 1'b1, sa_auto_pkg::SA6_FC4, 1'b0};
      sa_auto_pkg::RESP_LOSLFA4: r = '{1'b0, 1'b0, 1'b0, 1'b1, sa_auto_pkg::SA6_LOS, 1'b0};
      sa_auto_pkg::RESP_PWR:     r = '{1'b0, 1'b0, 1'b0, 1'b1, sa_auto_pkg::SA6_POWER, 1'b0};
      sa_auto_pkg::RESP_PWRLINE: r = '{1'b0, 1'b0, 1'b1, 1'b1, sa_auto_pkg::SA6_POWER, 1'b0};
      sa_auto_pkg::RESP_AUX:     r = '{1'b0, 1'b1, 1'b0, 1'b0, sa_auto_pkg::SA6_ZERO, 1'b1};
      default: r = '{1'b1, 1'b1, 1'b0, 1'b0, sa_auto_pkg::SA6_ZERO, 1'b0};
    endcase
    return r;
  endfunction

  // apb decode
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign hit_ctrl  = (paddr == sa_auto_pkg::CTRL1_ADDR);
  assign hit_stat  = (paddr == sa_auto_pkg::STAT_ADDR);
  // zero wait states; read data is fetched in the setup cycle
  assign pready    = 1'b1;
  assign pslverr   = access_ph & ~(hit_ctrl | hit_stat);
  assign wr_ctrl   = access_ph & pwrite & hit_ctrl & pstrb[0];
  assign ctrl_nxt  = wr_ctrl ? pwdata[sa_auto_pkg::CTRL_W-1:0] : ctrl_r;

  assign stat_word = {4'(sel_r), auto_active, power_loss, align_loss, signal_loss};
  assign prdata_nxt = !setup_ph ? prdata_r :
                      hit_ctrl  ? {24'h000000, ctrl_r} :
                      hit_stat  ? {24'h000000, stat_word} : 32'h00000000;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_r   <= sa_auto_pkg::CTRL1_RESET;
      prdata_r <= 32'h00000000;
    end else begin
      ctrl_r   <= ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // trigger terms, all from this channel's receive side and power pin
  assign line_loss = signal_loss | align_loss;
  assign trig[sa_auto_pkg::EN_LOSLFA1_BIT] = ctrl_r[sa_auto_pkg::EN_LOSLFA1_BIT] & line_loss;
  assign trig[sa_auto_pkg::EN_LOS1_BIT]    = ctrl_r[sa_auto_pkg::EN_LOS1_BIT] & signal_loss;
  assign trig[sa_auto_pkg::EN_LOSLFA2_BIT] = ctrl_r[sa_auto_pkg::EN_LOSLFA2_BIT] & line_loss;
  assign trig[sa_auto_pkg::EN_LOSLFA3_BIT] = ctrl_r[sa_auto_pkg::EN_LOSLFA3_BIT] & line_loss;
  assign trig[sa_auto_pkg::EN_LOSLFA4_BIT] = ctrl_r[sa_auto_pkg::EN_LOSLFA4_BIT] & line_loss;
  assign trig[sa_auto_pkg::EN_PWR_BIT]     = ctrl_r[sa_auto_pkg::EN_PWR_BIT] & power_loss;
  assign trig[sa_auto_pkg::EN_PWRLINE_BIT] =
    ctrl_r[sa_auto_pkg::EN_PWRLINE_BIT] & power_loss & line_loss;
  assign trig[sa_auto_pkg::EN_AUX_BIT]     = ctrl_r[sa_auto_pkg::EN_AUX_BIT] & signal_loss;

  assign sel_c   = pick(trig);
  assign resp_c  = resp_of(sel_c);
  assign restart = (sel_c != sel_r);

  sa_code_seq sa_code_seq_i (
    .clk_sys     (clk_sys),
    .rst_b       (rst_b),
    .nfas_strobe (nfas_strobe),
    .restart     (restart),
    .code_idx    (code_idx),
    .aux_bit     (aux_bit)
  );

  // code index counts up from the msb, so ~idx selects the bit
  assign code_bit = resp_c.sa6_code[~code_idx];

  always_comb begin
    tx_nxt = src_bits;
    if (!resp_c.use_src) begin
      tx_nxt.a = resp_c.a_keep ? src_bits.a : resp_c.a_val;
      if (resp_c.aux) begin
        tx_nxt.sa5 = aux_bit;
        tx_nxt.sa6 = aux_bit;
      end else begin
        tx_nxt.sa5 = resp_c.sa5_val;
        tx_nxt.sa6 = code_bit;
      end
    end
  end

  // one cycle of latency on the overhead path; the framer samples a stable bit
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_r  <= '0;
      sel_r <= sa_auto_pkg::RESP_NONE;
    end else begin
      tx_r  <= tx_nxt;
      sel_r <= sel_c;
    end
  end

  assign tx_bits     = tx_r;
  assign auto_active = (sel_r != sa_auto_pkg::RESP_NONE);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  wire hi7 = trig[7];
  wire hi6 = trig[7:6] != 2'b00;
  wire hi5 = trig[7:5] != 3'b000;
  wire hi4 = trig[7:4] != 4'h0;
  wire hi3 = trig[7:3] != 5'h00;
  wire hi2 = trig[7:2] != 6'h00;
  wire hi1 = trig[7:1] != 7'h00;

  property p_reset_clear;
    @(posedge clk_sys) disable iff (1'b0) !rst_b |=> (ctrl_r == 8'h00) && !auto_active;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enables not cleared by reset");

  property p_ctrl_rw;
    wr_ctrl |=> ctrl_r == $past(pwdata[7:0]);
  endproperty
  a_ctrl_rw: assert property (p_ctrl_rw) else $error("control write not stored");

  // read data is fetched in setup, so it shows the enables of that cycle
  property p_ctrl_read;
    (setup_ph && hit_ctrl && !pwrite) |=> prdata == {24'h000000, $past(ctrl_r)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback mismatch");

  property p_resp1;
    (ctrl_r[7] && line_loss) |=> tx_bits.sa5 && !tx_bits.sa6 && tx_bits.a == $past(src_bits.a);
  endproperty
  a_resp1: assert property (p_resp1) else $error("first line-loss response wrong");

  property p_resp2;
    (ctrl_r[6] && signal_loss && !hi7) |=>
      tx_bits.a && tx_bits.sa5 && tx_bits.sa6 == $past(code_idx != 2'h3);
  endproperty
  a_resp2: assert property (p_resp2) else $error("first los response wrong");

  property p_resp3;
    (ctrl_r[5] && line_loss && !hi6) |=> tx_bits.a && !tx_bits.sa5 && !tx_bits.sa6;
  endproperty
  a_resp3: assert property (p_resp3) else $error("second line-loss response wrong");

  property p_resp4;
    (ctrl_r[4] && line_loss && !hi5) |=>
      !tx_bits.a && tx_bits.sa5 && tx_bits.sa6 == $past(code_idx < 2'h2);
  endproperty
  a_resp4: assert property (p_resp4) else $error("third line-loss response wrong");

  property p_resp5;
    (ctrl_r[3] && line_loss && !hi4) |=>
      !tx_bits.a && tx_bits.sa5 && tx_bits.sa6 == $past(code_idx != 2'h3);
  endproperty
  a_resp5: assert property (p_resp5) else $error("fourth line-loss response wrong");

  property p_resp6;
    (ctrl_r[2] && power_loss && !hi3) |=>
      !tx_bits.a && tx_bits.sa5 && tx_bits.sa6 == $past(code_idx == 2'h0);
  endproperty
  a_resp6: assert property (p_resp6) else $error("power-fail response wrong");

  property p_pwr_low;
    (ctrl_r == 8'h04 && !power_loss) |=> tx_bits == $past(src_bits);
  endproperty
  a_pwr_low: assert property (p_pwr_low) else $error("low power pin treated as loss");

  property p_resp8;
    (ctrl_r[1] && power_loss && line_loss && !hi2) |=>
      tx_bits.a && tx_bits.sa5 && tx_bits.sa6 == $past(code_idx == 2'h0);
  endproperty
  a_resp8: assert property (p_resp8) else $error("combined response wrong");

  property p_aux;
    (ctrl_r[0] && signal_loss && !hi1) [*3] |=>
      tx_bits.sa5 == tx_bits.sa6 && tx_bits.sa5 == $past(aux_bit) &&
      tx_bits.a == $past(src_bits.a);
  endproperty
  a_aux: assert property (p_aux) else $error("aux pattern wrong");

  property p_aux_toggle;
    (sel_c == sa_auto_pkg::RESP_AUX && sel_r == sa_auto_pkg::RESP_AUX && nfas_strobe) |=>
      aux_bit != $past(aux_bit);
  endproperty
  a_aux_toggle: assert property (p_aux_toggle) else $error("aux pattern not alternating");

  property p_idle_pass;
    (trig == 8'h00) |=> tx_bits == $past(src_bits) && !auto_active;
  endproperty
  a_idle_pass: assert property (p_idle_pass) else $error("source bits not passed");

  property p_disabled;
    (ctrl_r == 8'h00) |=> !auto_active;
  endproperty
  a_disabled: assert property (p_disabled) else $error("response with no enable");

  property p_unmapped;
    (access_ph && !hit_ctrl && !hit_stat) |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  c_aux: cover property (sel_r == sa_auto_pkg::RESP_AUX && nfas_strobe);
  c_pwr: cover property (sel_r == sa_auto_pkg::RESP_PWRLINE);
  c_prio: cover property (trig[7] && trig[6]);
  c_write: cover property (wr_ctrl ##1 auto_active);

endmodule

// [include/sa_auto_pkg.sv]
package sa_auto_pkg;

  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned CTRL_W     = 8;

  // register indices; byte address is four times the index
  localparam logic [APB_ADDR_W-1:0] CTRL1_INDEX = 12'h131;
  localparam logic [APB_ADDR_W-1:0] STAT_INDEX  = 12'h13f;
  localparam logic [APB_ADDR_W-1:0] CTRL1_ADDR  = {CTRL1_INDEX[APB_ADDR_W-3:0], 2'b00};
  localparam logic [APB_ADDR_W-1:0] STAT_ADDR   = {STAT_INDEX[APB_ADDR_W-3:0], 2'b00};

  localparam logic [CTRL_W-1:0] CTRL1_RESET = 8'h00;

  // enable bit positions in the control register
  localparam int unsigned EN_LOSLFA1_BIT = 7;
  localparam int unsigned EN_LOS1_BIT    = 6;
  localparam int unsigned EN_LOSLFA2_BIT = 5;
  localparam int unsigned EN_LOSLFA3_BIT = 4;
  localparam int unsigned EN_LOSLFA4_BIT = 3;
  localparam int unsigned EN_PWR_BIT     = 2;
  localparam int unsigned EN_PWRLINE_BIT = 1;
  localparam int unsigned EN_AUX_BIT     = 0;

  // status field positions
  localparam int unsigned ST_LOS_BIT    = 0;
  localparam int unsigned ST_LFA_BIT    = 1;
  localparam int unsigned ST_PWR_BIT    = 2;
  localparam int unsigned ST_ACTIVE_BIT = 3;
  localparam int unsigned ST_SEL_LSB    = 4;

  // sa6 codes, sent msb first over four nfas frames
  localparam logic [3:0] SA6_ZERO  = 4'h0;
  localparam logic [3:0] SA6_LOS   = 4'he;
  localparam logic [3:0] SA6_FC4   = 4'hc;
  localparam logic [3:0] SA6_POWER = 4'h8;

  localparam logic       AUX_FIRST    = 1'b1;
  localparam logic [1:0] CODE_IDX_RST = 2'h0;

  typedef enum logic [3:0] {
    RESP_NONE,
    RESP_LOSLFA1,
    RESP_LOS1,
    RESP_LOSLFA2,
    RESP_LOSLFA3,
    RESP_LOSLFA4,
    RESP_PWR,
    RESP_PWRLINE,
    RESP_AUX
  } resp_sel_t;

  typedef struct packed {
    logic a;
    logic sa5;
    logic sa6;
  } oh_bits_t;

  typedef struct packed {
    logic       use_src;
    logic       a_keep;
    logic       a_val;
    logic       sa5_val;
    logic [3:0] sa6_code;
    logic       aux;
  } resp_t;

endpackage

// [hw/sa_code_seq.sv]
`timescale 1ns/1ps
module sa_code_seq (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       nfas_strobe,
  input  wire logic       restart,
  output logic [1:0]      code_idx,
  output logic            aux_bit
);

  logic [1:0] code_idx_r;
  logic [1:0] code_idx_nxt;
  logic       aux_r;
  logic       aux_nxt;

  // a new response starts its code at the msb
  assign code_idx_nxt = restart ? sa_auto_pkg::CODE_IDX_RST :
                        nfas_strobe ? 2'(code_idx_r + 2'h1) : code_idx_r;
  assign aux_nxt      = restart ? sa_auto_pkg::AUX_FIRST :
                        nfas_strobe ? ~aux_r : aux_r;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      code_idx_r <= sa_auto_pkg::CODE_IDX_RST;
      aux_r      <= sa_auto_pkg::AUX_FIRST;
    end else begin
      code_idx_r <= code_idx_nxt;
      aux_r      <= aux_nxt;
    end
  end

  assign code_idx = code_idx_r;
  assign aux_bit  = aux_r;

endmodule

// [test/e1_far_end_model.sv]
`timescale 1ns/1ps
module e1_far_end_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  run,
  input  wire sa_auto_pkg::oh_bits_t tx_bits,
  output logic                       nfas_strobe,
  output logic [7:0]                 sa5_seen,
  output logic [7:0]                 sa6_seen
);
  logic [2:0] cnt_r;
  // eight-cycle frames only while run; strobe stays low between runs
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_r <= 3'h0;
      nfas_strobe <= 1'b0;
      sa5_seen <= 8'h00;
      sa6_seen <= 8'h00;
    end else begin
      cnt_r <= run ? cnt_r + 3'h1 : 3'h0;
      nfas_strobe <= run && (cnt_r == 3'h6);
      // sample mid-frame, well clear of the strobe
      if (run && (cnt_r == 3'h4)) begin
        sa5_seen <= {sa5_seen[6:0], tx_bits.sa5};
        sa6_seen <= {sa6_seen[6:0], tx_bits.sa6};
      end
    end
  end
endmodule

// [test/e1_auto_sa_alarm_response_bench.sv]
`timescale 1ns/1ps
module e1_auto_sa_alarm_response_bench;
  logic                  clk_sys = 1'b0;
  logic                  rst_b = 1'b0;
  logic [11:0]           paddr = 12'h000;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [31:0]           pwdata = 32'h0;
  logic [3:0]            pstrb = 4'hf;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  los = 1'b0;
  logic                  lfa = 1'b0;
  logic                  pwr = 1'b0;
  logic                  nfas;
  logic                  run = 1'b0;
  logic [7:0]            sa5_seen;
  logic [7:0]            sa6_seen;
  sa_auto_pkg::oh_bits_t src = 3'h7;
  sa_auto_pkg::oh_bits_t tx;
  logic                  active;
  int                    fail_count = 0;
  int                    checks = 0;
  int                    cyc = 0;
  logic [31:0]           rd;
  logic                  err;

  always #4 clk_sys = ~clk_sys;

  e1_auto_sa_alarm_response e1_auto_sa_alarm_response_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .signal_loss(los), .align_loss(lfa), .power_loss(pwr),
    .nfas_strobe(nfas), .src_bits(src), .tx_bits(tx), .auto_active(active));

  e1_far_end_model e1_far_end_model_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .run(run), .tx_bits(tx), .nfas_strobe(nfas),
    .sa5_seen(sa5_seen), .sa6_seen(sa6_seen));

  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // generous: the whole sequence needs under two thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bits(string nm, logic [3:0] e, logic [3:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // wait states are not assumed; the timeout cuts a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic test_regs();
    apb(1'b0, sa_auto_pkg::CTRL1_ADDR, 32'h0);
    chk32("ctrl reset", 32'h0, rd);
    apb(1'b1, sa_auto_pkg::CTRL1_ADDR, 32'ha5);
    apb(1'b1, sa_auto_pkg::STAT_ADDR, 32'hff);
    apb(1'b0, sa_auto_pkg::CTRL1_ADDR, 32'h0);
    chk32("ctrl a5", 32'ha5, rd);
    apb(1'b1, sa_auto_pkg::CTRL1_ADDR, 32'h5a);
    pstrb <= 4'h0;
    apb(1'b1, sa_auto_pkg::CTRL1_ADDR, 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, sa_auto_pkg::CTRL1_ADDR, 32'h0);
    chk32("ctrl 5a", 32'h5a, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk32("unmapped err", 32'h1, {31'h0, err});
    chk32("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask

  // c: los, lfa, pwr; n frames collected; patterns compared on their low n bits
  task automatic resp(string nm, logic [7:0] ctl, logic [2:0] c, logic ea,
                      logic [7:0] e5, logic [7:0] e6, int n);
    logic [7:0] m;
    m = (n == 8) ? 8'hff : 8'h0f;
    apb(1'b1, sa_auto_pkg::CTRL1_ADDR, {24'h0, ctl});
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bits("idle pass", {1'b0, src}, {active, tx});
    @(posedge clk_sys);
    {los, lfa, pwr} <= c;
    repeat (3) @(posedge clk_sys);
    run <= 1'b1;
    repeat (8 * n) @(posedge clk_sys);
    run <= 1'b0;
    @(negedge clk_sys);
    chk_bits("a and active", {1'b1, 2'h0, ea}, {active, 2'h0, tx.a});
    chk32("sa5 frames", {24'h0, e5 & m}, {24'h0, sa5_seen & m});
    chk32("sa6 frames", {24'h0, e6 & m}, {24'h0, sa6_seen & m});
    @(posedge clk_sys);
    {los, lfa, pwr} <= 3'h0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bits("released", {1'b0, src}, {active, tx});
    $display("test %s done", nm);
  endtask

  // reset in mid-run must drop an active response and clear the enables
  task automatic test_reset();
    apb(1'b1, sa_auto_pkg::CTRL1_ADDR, 32'h40);
    @(posedge clk_sys);
    los <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_bits("active before reset", 4'h8, {active, 3'h0});
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    chk_bits("active after reset", 4'h0, {active, tx});
    apb(1'b0, sa_auto_pkg::CTRL1_ADDR, 32'h0);
    chk32("ctrl after reset", 32'h0, rd);
    @(posedge clk_sys);
    los <= 1'b0;
    $display("test reset done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    chk_bits("reset out", 4'h0, {active, tx});
    test_regs();
    resp("fc2", 8'h80, 3'b010, 1'b1, 8'hff, 8'h00, 4);
    resp("fc3", 8'h40, 3'b100, 1'b1, 8'hff, 8'h0e, 4);
    resp("fcl", 8'h20, 3'b100, 1'b1, 8'h00, 8'h00, 4);
    resp("fc4", 8'h10, 3'b010, 1'b0, 8'hff, 8'h0c, 4);
    resp("fc34", 8'h08, 3'b100, 1'b0, 8'hff, 8'h0e, 4);
    resp("power", 8'h04, 3'b001, 1'b0, 8'hff, 8'h08, 4);
    resp("power line", 8'h02, 3'b011, 1'b1, 8'hff, 8'h08, 4);
    resp("aux", 8'h01, 3'b100, 1'b1, 8'haa, 8'haa, 8);
    resp("top wins", 8'hff, 3'b101, 1'b1, 8'hff, 8'h00, 4);
    resp("next wins", 8'h7f, 3'b101, 1'b1, 8'hff, 8'h0e, 4);
    resp("power beats combo", 8'h06, 3'b011, 1'b0, 8'hff, 8'h08, 4);
    test_reset();
    // all-zero source tells forced ones and a passed A apart
    @(posedge clk_sys);
    src <= 3'h0;
    resp("fc2 src low", 8'h80, 3'b010, 1'b0, 8'hff, 8'h00, 4);
    resp("fc3 src low", 8'h40, 3'b100, 1'b1, 8'hff, 8'h0e, 4);
    resp("aux src low", 8'h01, 3'b100, 1'b0, 8'haa, 8'haa, 8);
    test_done();
  end
endmodule
